/* File: design/nv_pkg.sv */
// Constants for the data EEPROM access controller.
// Assumes one 250 MHz clock; firmware register writes arrive as strobes.
// Contract
// - Read-start with program select clear reads the byte at the address; the code ignores a read-start while a write is busy.
// - Read data appears in the data register on the next cycle.
// - Data register holds read value until next read or direct write.
// - Write needs address, data, program select clear and write enable set.
// - Write-start only accepted if write enable was set earlier.
// - Clearing write enable during a write does not abort it.
// - Unlock register must receive 55h then AAh before write-start.
// - At write end hardware clears write-start and sets complete flag.
// - Each write programs one 8-bit byte at the given address.
package nv_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int DEPTH = 256;
	localparam logic [7:0] UNLOCK_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
	localparam int WRITE_TIME_US = 4;
	localparam int CLK_MHZ = 250;
	localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	typedef enum logic [1:0] {
		UNL_IDLE = 2'b00,
		UNL_FIRST = 2'b01,
		UNL_ARMED = 2'b11
	} unlock_state_t;
endpackage : nv_pkg

/* File: design/nv_array.sv */
// Byte-wide storage array standing in for the data EEPROM cells.
// Assumes write strobes come only from the controller's write sequencer.
module nv_array #(
	parameter int AW = 8,
	parameter int DW = 8,
	parameter int DEPTH = 256
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];

	initial begin
		if (DEPTH > (1 << AW))
			$error("Depth exceeds address range");
	end

	// Asynchronous read so a read lands in the data register next cycle
	assign rdata = mem[addr];

	always_ff @(posedge clk) begin
		if (wr_en)
			mem[addr] <= wdata;
	end
endmodule : nv_array

/* File: design/nv_data_access.sv */
// Data EEPROM access controller: read, unlock-guarded write, completion flag.
// Assumes register strobes are one-cycle pulses synchronous to CLK.
module nv_data_access #(
	parameter int WRITE_CYCLES = nv_pkg::WRITE_CYCLES
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic ADDR_WE,
	input wire logic [nv_pkg::ADDR_W-1:0] ADDR_WDATA,
	input wire logic DATA_WE,
	input wire logic [nv_pkg::DATA_W-1:0] DATA_WDATA,
	input wire logic UNLOCK_WE,
	input wire logic [7:0] UNLOCK_WDATA,
	input wire logic CTRL_WE,
	input wire logic PROGRAM_MEMORY_SELECT,
	input wire logic WRITE_ENABLE,
	input wire logic WRITE_START,
	input wire logic READ_START,
	input wire logic FLAG_CLEAR,
	output logic [nv_pkg::ADDR_W-1:0] NV_ADDRESS,
	output logic [nv_pkg::DATA_W-1:0] NV_DATA,
	output logic PROGRAM_SELECT_Q,
	output logic WRITE_ENABLE_Q,
	output logic WRITE_BUSY,
	output logic WRITE_COMPLETE_FLAG
);
	localparam int CW = $clog2(WRITE_CYCLES + 1);

	// A zero write time would leave the timer unable to end a write
	initial begin
		if (WRITE_CYCLES < 1)
			$error("WRITE_CYCLES must be at least one");
		if (nv_pkg::DEPTH > (1 << nv_pkg::ADDR_W))
			$error("Depth exceeds address range");
		if (nv_pkg::DATA_W != 8)
			$error("Cells must be one byte wide");
	end

	// Register and next-value pairs, one pair per state bit group
	logic [nv_pkg::ADDR_W-1:0] nv_address_reg;
	logic [nv_pkg::ADDR_W-1:0] nv_address_next;
	logic [nv_pkg::DATA_W-1:0] nv_data_reg;
	logic [nv_pkg::DATA_W-1:0] nv_data_next;
	logic pgm_sel_reg;
	logic pgm_sel_next;
	logic write_enable_reg;
	logic write_enable_next;
	logic busy_reg;
	logic busy_next;
	logic flag_reg;
	logic flag_next;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	nv_pkg::unlock_state_t unl_reg;
	nv_pkg::unlock_state_t unl_next;
	logic [nv_pkg::DATA_W-1:0] array_rdata;
	logic array_we;
	logic start_ok;
	logic read_ok;
	logic last_cycle;

	nv_array #(
		.AW(nv_pkg::ADDR_W),
		.DW(nv_pkg::DATA_W),
		.DEPTH(nv_pkg::DEPTH)
	) u_array (
		.clk(CLK),
		.wr_en(array_we),
		.addr(nv_address_reg),
		.wdata(nv_data_reg),
		.rdata(array_rdata)
	);

	// Program space lies outside this block; only data space is served
	function automatic logic data_space(input logic select);
		return !select;
	endfunction : data_space

	// Exact match of an unlock register write against one key
	function automatic logic is_key(input logic [7:0] value,
		input logic [7:0] key);
		return value == key;
	endfunction : is_key

	// Write enable must already be set, select clear, unlock armed, idle
	assign start_ok = CTRL_WE && WRITE_START && write_enable_reg
		&& data_space(PROGRAM_MEMORY_SELECT)
		&& unl_reg == nv_pkg::UNL_ARMED
		&& !busy_reg;
	// A read during a write would return a cell still being programmed
	assign read_ok = CTRL_WE && READ_START
		&& data_space(PROGRAM_MEMORY_SELECT) && !busy_reg;
	// Cells programmed once at the end of the cycle
	assign last_cycle = busy_reg && count_reg == CW'(1);
	assign array_we = last_cycle;

	// Unlock tracker: 55h then AAh on consecutive unlock writes, with no address, data or control write between
	always_comb begin
		unl_next = unl_reg;
		if (UNLOCK_WE) begin
			case (unl_reg)
				nv_pkg::UNL_FIRST: begin
					if (is_key(UNLOCK_WDATA, nv_pkg::UNLOCK_SECOND))
						unl_next = nv_pkg::UNL_ARMED;
					else if (is_key(UNLOCK_WDATA, nv_pkg::UNLOCK_FIRST))
						unl_next = nv_pkg::UNL_FIRST;
					else
						unl_next = nv_pkg::UNL_IDLE;
				end
				nv_pkg::UNL_IDLE: begin
					if (is_key(UNLOCK_WDATA, nv_pkg::UNLOCK_FIRST))
						unl_next = nv_pkg::UNL_FIRST;
					else
						unl_next = nv_pkg::UNL_IDLE;
				end
				nv_pkg::UNL_ARMED: begin
					// Arming is not kept across a further unlock write
					if (is_key(UNLOCK_WDATA, nv_pkg::UNLOCK_FIRST))
						unl_next = nv_pkg::UNL_FIRST;
					else
						unl_next = nv_pkg::UNL_IDLE;
				end
				default: begin
					unl_next = nv_pkg::UNL_IDLE;
				end
			endcase
		end else if (CTRL_WE || ADDR_WE || DATA_WE) begin
			// An address, data or control write breaks the sequence; a flag clear does not
			unl_next = nv_pkg::UNL_IDLE;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			unl_reg <= nv_pkg::UNL_IDLE;
		end else begin
			unl_reg <= unl_next;
		end
	end

	// Firmware-visible address, data and control bits
	always_comb begin
		nv_address_next = nv_address_reg;
		nv_data_next = nv_data_reg;
		pgm_sel_next = pgm_sel_reg;
		write_enable_next = write_enable_reg;
		// Address and data frozen while busy so the byte stays coherent
		if (ADDR_WE && !busy_reg)
			nv_address_next = ADDR_WDATA;
		if (DATA_WE && !busy_reg)
			nv_data_next = DATA_WDATA;
		if (CTRL_WE) begin
			pgm_sel_next = PROGRAM_MEMORY_SELECT;
			// Only the bit changes; the write timer runs on regardless
			write_enable_next = WRITE_ENABLE;
		end
		if (read_ok)
			nv_data_next = array_rdata;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			nv_address_reg <= nv_pkg::ADDR_RESET;
			nv_data_reg <= nv_pkg::DATA_RESET;
			pgm_sel_reg <= 1'b0;
			write_enable_reg <= 1'b0;
		end else begin
			nv_address_reg <= nv_address_next;
			nv_data_reg <= nv_data_next;
			pgm_sel_reg <= pgm_sel_next;
			write_enable_reg <= write_enable_next;
		end
	end

	// Write timer; reloads only from idle, a start while busy is refused
	always_comb begin
		busy_next = busy_reg;
		count_next = count_reg;
		if (start_ok) begin
			busy_next = 1'b1;
			count_next = CW'(WRITE_CYCLES);
		end else if (busy_reg) begin
			count_next = count_reg - CW'(1);
			if (last_cycle)
				busy_next = 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			busy_reg <= 1'b0;
			count_reg <= '0;
		end else begin
			busy_reg <= busy_next;
			count_reg <= count_next;
		end
	end

	// Completion flag, sticky until firmware clears it
	always_comb begin
		flag_next = flag_reg;
		if (FLAG_CLEAR)
			flag_next = 1'b0;
		// Set beats a clear in the same cycle so no completion is lost
		if (array_we)
			flag_next = 1'b1;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	// Every output comes straight from a flip-flop
	assign NV_ADDRESS = nv_address_reg;
	assign NV_DATA = nv_data_reg;
	assign PROGRAM_SELECT_Q = pgm_sel_reg;
	assign WRITE_ENABLE_Q = write_enable_reg;
	assign WRITE_BUSY = busy_reg;
	assign WRITE_COMPLETE_FLAG = flag_reg;
endmodule : nv_data_access

/* File: bench/nv_sva.sv */
// Port assertions for the data EEPROM controller.
// Bound to nv_data_access; one clock, RST async high.
module nv_sva #(
	parameter int WRITE_CYCLES = 8
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic DATA_WE,
	input wire logic [nv_pkg::DATA_W-1:0] DATA_WDATA,
	input wire logic CTRL_WE,
	input wire logic WRITE_ENABLE,
	input wire logic WRITE_START,
	input wire logic READ_START,
	input wire logic FLAG_CLEAR,
	input wire logic [nv_pkg::DATA_W-1:0] NV_DATA,
	input wire logic WRITE_ENABLE_Q,
	input wire logic WRITE_BUSY,
	input wire logic WRITE_COMPLETE_FLAG
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// Repeat count fixed at 8 to match the bench parameter
	sequence busy_run;
		WRITE_BUSY[*8] ##1 !WRITE_BUSY;
	endsequence
	write_time_a: assert property ($rose(WRITE_BUSY) |-> busy_run)
		else $error("write length wrong");
	flag_set_a: assert property ($fell(WRITE_BUSY) |-> WRITE_COMPLETE_FLAG)
		else $error("flag not set");
	write_enable_first_a: assert property (CTRL_WE && WRITE_START && !WRITE_ENABLE_Q
		&& !WRITE_BUSY |=> !WRITE_BUSY) else $error("early start");
	no_abort_a: assert property (WRITE_BUSY && CTRL_WE && !WRITE_ENABLE
		|=> WRITE_BUSY || WRITE_COMPLETE_FLAG) else $error("write aborted");
	flag_hold_a: assert property (WRITE_COMPLETE_FLAG && !FLAG_CLEAR
		|=> WRITE_COMPLETE_FLAG) else $error("flag lost");
	flag_clr_a: assert property (FLAG_CLEAR && !WRITE_BUSY
		|=> !WRITE_COMPLETE_FLAG) else $error("flag kept");
	data_hold_a: assert property (!(CTRL_WE && READ_START) && !DATA_WE
		|=> $stable(NV_DATA)) else $error("data moved");
	data_load_a: assert property (DATA_WE && !CTRL_WE && !WRITE_BUSY
		|=> NV_DATA == $past(DATA_WDATA)) else $error("data not loaded");
	// Counted, since a repetition cannot follow the parameter
	int unsigned busy_len;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			busy_len <= 0;
		else if (WRITE_BUSY)
			busy_len <= busy_len + 1;
		else
			busy_len <= 0;
	end
	busy_len_a: assert property ($fell(WRITE_BUSY) |->
		busy_len == WRITE_CYCLES) else $error("write cut short");
endmodule : nv_sva

bind nv_data_access nv_sva #(.WRITE_CYCLES(WRITE_CYCLES)) sva_u (
	.CLK(CLK),
	.RST(RST),
	.DATA_WE(DATA_WE),
	.DATA_WDATA(DATA_WDATA),
	.CTRL_WE(CTRL_WE),
	.WRITE_ENABLE(WRITE_ENABLE),
	.WRITE_START(WRITE_START),
	.READ_START(READ_START),
	.FLAG_CLEAR(FLAG_CLEAR),
	.NV_DATA(NV_DATA),
	.WRITE_ENABLE_Q(WRITE_ENABLE_Q),
	.WRITE_BUSY(WRITE_BUSY),
	.WRITE_COMPLETE_FLAG(WRITE_COMPLETE_FLAG)
);

/* File: bench/eeprom_data_access_bench.sv */
// Self-checking bench: writes, refused writes and reads against a model.
// Drives strobes at falling edges; short write time for speed.
module eeprom_data_access_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK = 0, RST = 1, ADDR_WE = 0, DATA_WE = 0, UNLOCK_WE = 0;
	logic CTRL_WE = 0, PROGRAM_MEMORY_SELECT = 0, WRITE_ENABLE = 0;
	logic WRITE_START = 0, READ_START = 0, FLAG_CLEAR = 0;
	logic [7:0] ADDR_WDATA = 0, DATA_WDATA = 0, UNLOCK_WDATA = 0;
	logic [7:0] NV_ADDRESS, NV_DATA, mem [logic [7:0]];
	logic PROGRAM_SELECT_Q, WRITE_ENABLE_Q, WRITE_BUSY, WRITE_COMPLETE_FLAG;
	int checks = 0, miscompares = 0;
	logic [7:0] a;
	nv_data_access #(.WRITE_CYCLES(8)) dut_u (
		.CLK(CLK),
		.RST(RST),
		.ADDR_WE(ADDR_WE),
		.ADDR_WDATA(ADDR_WDATA),
		.DATA_WE(DATA_WE),
		.DATA_WDATA(DATA_WDATA),
		.UNLOCK_WE(UNLOCK_WE),
		.UNLOCK_WDATA(UNLOCK_WDATA),
		.CTRL_WE(CTRL_WE),
		.PROGRAM_MEMORY_SELECT(PROGRAM_MEMORY_SELECT),
		.WRITE_ENABLE(WRITE_ENABLE),
		.WRITE_START(WRITE_START),
		.READ_START(READ_START),
		.FLAG_CLEAR(FLAG_CLEAR),
		.NV_ADDRESS(NV_ADDRESS),
		.NV_DATA(NV_DATA),
		.PROGRAM_SELECT_Q(PROGRAM_SELECT_Q),
		.WRITE_ENABLE_Q(WRITE_ENABLE_Q),
		.WRITE_BUSY(WRITE_BUSY),
		.WRITE_COMPLETE_FLAG(WRITE_COMPLETE_FLAG)
	);
	always #2 CLK = ~CLK;
	task chk(input logic [7:0] g, e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Strobe bits: addr, data, unlock, ctrl, clear
	task op(input logic [4:0] s, input logic [7:0] v, input logic [3:0] c);
		@(negedge CLK);
		{ADDR_WE, DATA_WE, UNLOCK_WE, CTRL_WE, FLAG_CLEAR} = s;
		{ADDR_WDATA, DATA_WDATA, UNLOCK_WDATA} = {3{v}};
		{PROGRAM_MEMORY_SELECT, WRITE_ENABLE, WRITE_START, READ_START} = c;
		@(negedge CLK);
		{ADDR_WE, DATA_WE, UNLOCK_WE, CTRL_WE, FLAG_CLEAR} = 5'h00;
	endtask : op
	task rd(input logic [7:0] ad);
		op(5'h10, ad, 4'h0);
		op(5'h02, 8'h00, 4'h1);
		chk(NV_DATA, mem[ad]);
	endtask : rd
	// Mode 0 legal, 1 enable in same op, 2 bad unlock, 3 program select
	task wr(input logic [7:0] ad, d, input int m);
		int n;
		chk(WRITE_BUSY, 1'b0);
		op(5'h10, ad, 4'h0);
		chk(NV_ADDRESS, ad);
		op(5'h08, d, 4'h0);
		op(5'h02, 8'h00, {1'b0, m != 1, 2'b00});
		chk(WRITE_ENABLE_Q, m != 1);
		op(5'h04, 8'h55, 4'h0);
		op(5'h04, (m == 2) ? 8'h5A : 8'hAA, 4'h0);
		op(5'h02, 8'h00, {m == 3, 3'h6});
		chk(PROGRAM_SELECT_Q, m == 3);
		chk(WRITE_BUSY, m == 0);
		if (m == 0) begin
			op(5'h02, 8'h00, 4'h0);
			chk(WRITE_ENABLE_Q, 1'b0);
			chk(WRITE_BUSY, 1'b1);
			// Address and data writes are shut out while the cell programs
			op(5'h10, ~ad, 4'h0);
			chk(NV_ADDRESS, ad);
			op(5'h08, ~d, 4'h0);
			chk(NV_DATA, d);
			for (n = 0; n < 20 && WRITE_BUSY === 1'b1; n++) @(negedge CLK);
			chk(WRITE_COMPLETE_FLAG, 1'b1);
			mem[ad] = d;
			op(5'h01, 8'h00, 4'h0);
			chk(WRITE_COMPLETE_FLAG, 1'b0);
		end else begin
			chk(WRITE_COMPLETE_FLAG, 1'b0);
		end
		rd(ad);
	endtask : wr
	task test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	initial begin
		#40000;
		miscompares++;
		test_done;
	end
	initial begin
		void'($urandom(32'h2815630D));
		repeat (16) @(posedge CLK);
		@(negedge CLK) RST = 0;
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			wr(a, 8'($urandom), 0);
		end
		$display("test 1 done");
		// Refused writes must leave the cell as it was
		for (int m = 1; m < 4; m++) wr(a, 8'($urandom), m);
		$display("test 2 done");
		test_done;
	end
endmodule : eeprom_data_access_bench
